/* rtl/ptid_defines.svh */
`ifndef PTID_DEFINES_SVH
`define PTID_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses on the local register port).
`define PTID_OFS_IMG1_CTL   12'h110
`define PTID_OFS_IMG1_ADDR  12'h114
`define PTID_OFS_ROM_CTL    12'h13c

// ==========================================================================
// Image 1 control register fields.
`define PTID_CTL_EN         31
`define PTID_CTL_BS_HI      27
`define PTID_CTL_BS_LO      24
`define PTID_CTL_PREFETCH_READ_ON       23
`define PTID_CTL_BRST       22
`define PTID_CTL_INV        20
`define PTID_CTL_TC_HI      15
`define PTID_CTL_TC_LO      12
`define PTID_CTL_DS_HI      11
`define PTID_CTL_DS_LO      10
`define PTID_CTL_POSTED_WRITE_ON       7
`define PTID_CTL_PAS        6

// ==========================================================================
// Image 1 address register and expansion-ROM control register fields.
`define PTID_ADDR_BA_HI     31
`define PTID_ADDR_BA_LO     16
`define PTID_ADDR_TA_HI     15
`define PTID_ADDR_TA_LO     0
`define PTID_ROM_DS_HI      25
`define PTID_ROM_DS_LO      24
`define PTID_ROM_BS_HI      22
`define PTID_ROM_BS_LO      20
`define PTID_ROM_TC_HI      19
`define PTID_ROM_TC_LO      16
`define PTID_ROM_TA_HI      15
`define PTID_ROM_TA_LO      0

// ==========================================================================
// Reset values and encodings.
`define PTID_ZERO32         32'h0000_0000
`define PTID_ZERO16         16'h0000
`define PTID_ZERO4          4'h0
`define PTID_ZERO3          3'h0
`define PTID_ZERO2          2'h0
`define PTID_SPACE_MEM      1'b0
`define PTID_SPACE_IO       1'b1
`define PTID_DS_32          2'h0
`define PTID_DS_8           2'h1
`define PTID_DS_16          2'h2

`endif

/* rtl/ptid_pkg.sv */
package ptid_pkg;

  // ==========================================================================
  // PCI address phase presented to the decoder.
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        io_space;
    logic        rom;
    logic        write;
    logic        burst;
  } ptid_req_t;

  // ==========================================================================
  // Decode result handed to the local-bus side.
  typedef struct packed {
    logic        claim;
    logic        rom_hit;
    logic [31:0] local_addr;
    logic [3:0]  local_txn_code;
    logic [1:0]  dest_port_width;
    logic        byte_order;
    logic        prefetch_ok;
    logic        burst_ok;
    logic        post_ok;
  } ptid_resp_t;

  // ==========================================================================
  // Preload values from the serial EEPROM controller.
  typedef struct packed {
    logic        done;
    logic        img1_loaded;
    logic [3:0]  img1_block_size_code;
    logic        img1_space;
    logic        bst1_enable;
    logic        rom_enable;
    logic [31:0] rom_value;
  } ptid_eeprom_t;

  // ==========================================================================
  // Configuration-space base registers that the decoder mirrors or compares.
  typedef struct packed {
    logic [15:0] img1_base;
    logic        img1_space;
    logic [15:0] rom_base;
    logic        rom_enable;
  } ptid_cfg_t;

endpackage

/* rtl/ptid_sync2.sv */
`timescale 1ns/1ns

// Two-flop synchroniser for pins; the first stage feeds only the second.
module ptid_sync2
  import ptid_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= pin_in;
      sync_out <= stage1;
    end
  end

endmodule

/* rtl/ptid_target_decode.sv */
`timescale 1ns/1ns
`include "ptid_defines.svh"

// Behaviour
// - Image 1 claims nothing unless its enable bit is set; enable resets to 0.
// - Block size is 64 Kbytes times two to the 4-bit size code.
// - Address phase compares selected upper lines with base field bits 31:16.
// - Compared upper lines are replaced by translation field bits on the local bus.
// - Prefetching reads only when prefetch bit is 1; resets to 0.
// - Burst writes only when burst-write bit is 1; resets to 0.
// - Invert bit 0 keeps global byte order, 1 inverts it.
// - Drive 4-bit transaction code and port width 32, 8, 16 bit.
// - Writes are posted only when posting enabled and memory space.
// - Space bit 0 decodes memory, 1 decodes I/O accesses.
// - EEPROM-loaded size and space fields take its values and become read-only.
// - When loaded and the disable strap is low, control space bit follows the configuration base register space bit.
// - Not loaded: size and space reset to 0, writable; configuration base absent unless byte 9 bit 7 or strap is set.
// - Disable strap high at reset keeps size and space writable anyway.
// - EEPROM byte 9 bit 7 or strap makes base read-only, mirroring configuration.
// - Otherwise base is read-write, resets to zero, independent of configuration.
// - Translation field is always read-write and resets to 0.
// - ROM control loads from EEPROM when ident strap high and byte 5 bit 7.
// - Without that preload the ROM control register is zero and ignores writes.
// - ROM compare uses the 3-bit ROM size code, 64 Kbyte times two to it.
// - ROM accesses substitute ROM translation bits, ROM port width and code.
module ptid_target_decode
  import ptid_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         pci_reset_pin,
  input  wire logic         pci_disable_strap,
  input  wire logic         eeprom_ident_strap,
  input  wire logic         local_byte_order_setting,
  input  wire ptid_eeprom_t eeprom,
  input  wire ptid_cfg_t    cfg,
  input  wire logic [11:0]  reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [31:0]  reg_wdata,
  output logic      [31:0]  reg_rdata,
  output logic              reg_ack,
  input  wire ptid_req_t    req,
  output ptid_resp_t        resp,
  output logic              cfg_image1_base_reg_on
);

  // ==========================================================================
  // Pin synchronisation and strap capture.
  logic [2:0] pins_s;
  logic       pci_rst_s;
  logic       dis_s;
  logic       ident_s;
  logic       strap_dis;
  logic       strap_ident;
  logic       pci_rst_any;

  ptid_sync2 #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({pci_reset_pin, pci_disable_strap, eeprom_ident_strap}),
    .sync_out (pins_s)
  );

  assign pci_rst_s   = pins_s[2];
  assign dis_s       = pins_s[1];
  assign ident_s     = pins_s[0];
  assign pci_rst_any = reset || pci_rst_s;

  // Straps follow the pins while PCI reset is held and freeze at its release.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_dis   <= 1'b0;
      strap_ident <= 1'b0;
    end
    else if (pci_rst_s)
    begin
      strap_dis   <= dis_s;
      strap_ident <= ident_s;
    end
  end

  // ==========================================================================
  // Preload status, taken when the EEPROM controller finishes after PCI reset.
  logic img1_loaded;
  logic bst1_on;
  logic rom_loaded;

  always_ff @(posedge clk)
  begin
    if (pci_rst_any)
    begin
      img1_loaded <= 1'b0;
      bst1_on     <= 1'b0;
      rom_loaded  <= 1'b0;
    end
    else if (eeprom.done)
    begin
      img1_loaded <= eeprom.img1_loaded;
      bst1_on     <= eeprom.bst1_enable || strap_dis;
      rom_loaded  <= strap_ident && eeprom.rom_enable;
    end
  end

  // Size and space stay writable unless loaded, and the strap overrides it.
  logic bs_pas_writable;
  assign bs_pas_writable = !img1_loaded || strap_dis;

  // ==========================================================================
  // Register write decode.
  logic wr_ctl;
  logic wr_addr;
  logic wr_rom;

  assign wr_ctl  = reg_wr && (reg_addr == `PTID_OFS_IMG1_CTL);
  assign wr_addr = reg_wr && (reg_addr == `PTID_OFS_IMG1_ADDR);
  assign wr_rom  = reg_wr && (reg_addr == `PTID_OFS_ROM_CTL);

  // ==========================================================================
  // Image 1 control fields held by global reset.
  logic       img_en;
  logic       prefetch_read_on;
  logic       burst_write_on;
  logic       byte_order_invert;
  logic [3:0] local_txn_code;
  logic [1:0] dest_port_width;
  logic       posted_write_on;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      img_en            <= 1'b0;
      prefetch_read_on  <= 1'b0;
      burst_write_on    <= 1'b0;
      byte_order_invert <= 1'b0;
      local_txn_code    <= `PTID_ZERO4;
      dest_port_width   <= `PTID_DS_32;
      posted_write_on   <= 1'b0;
    end
    else if (wr_ctl)
    begin
      img_en            <= reg_wdata[`PTID_CTL_EN];
      prefetch_read_on  <= reg_wdata[`PTID_CTL_PREFETCH_READ_ON];
      burst_write_on    <= reg_wdata[`PTID_CTL_BRST];
      byte_order_invert <= reg_wdata[`PTID_CTL_INV];
      local_txn_code    <= reg_wdata[`PTID_CTL_TC_HI:`PTID_CTL_TC_LO];
      dest_port_width   <= reg_wdata[`PTID_CTL_DS_HI:`PTID_CTL_DS_LO];
      posted_write_on   <= reg_wdata[`PTID_CTL_POSTED_WRITE_ON];
    end
  end

  // ==========================================================================
  // Image 1 size and space fields held by PCI reset.
  logic [3:0] block_size_code;
  logic       pci_space_reg;
  logic       pci_space_select;

  always_ff @(posedge clk)
  begin
    if (pci_rst_any)
    begin
      block_size_code <= `PTID_ZERO4;
      pci_space_reg   <= `PTID_SPACE_MEM;
    end
    else if (eeprom.done && eeprom.img1_loaded)
    begin
      block_size_code <= eeprom.img1_block_size_code;
      pci_space_reg   <= eeprom.img1_space;
    end
    else if (wr_ctl && bs_pas_writable)
    begin
      block_size_code <= reg_wdata[`PTID_CTL_BS_HI:`PTID_CTL_BS_LO];
      pci_space_reg   <= reg_wdata[`PTID_CTL_PAS];
    end
  end

  // A loaded, locked space bit always agrees with the configuration register.
  assign pci_space_select = (img1_loaded && !strap_dis) ? cfg.img1_space
                                                        : pci_space_reg;

  // ==========================================================================
  // Image 1 base and translation fields.
  logic [15:0] base_reg;
  logic [15:0] base_eff;
  logic [15:0] xlate_addr_field;

  always_ff @(posedge clk)
  begin
    if (pci_rst_any)
    begin
      base_reg <= `PTID_ZERO16;
    end
    else if (wr_addr && !bst1_on)
    begin
      base_reg <= reg_wdata[`PTID_ADDR_BA_HI:`PTID_ADDR_BA_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      xlate_addr_field <= `PTID_ZERO16;
    end
    else if (wr_addr)
    begin
      xlate_addr_field <= reg_wdata[`PTID_ADDR_TA_HI:`PTID_ADDR_TA_LO];
    end
  end

  // Mirroring is combinational so the field tracks later configuration writes.
  assign base_eff = bst1_on ? cfg.img1_base : base_reg;

  // ==========================================================================
  // Expansion-ROM control register.
  logic [31:0] rom_ctl;

  always_ff @(posedge clk)
  begin
    if (pci_rst_any)
    begin
      rom_ctl <= `PTID_ZERO32;
    end
    else if (eeprom.done && strap_ident && eeprom.rom_enable)
    begin
      rom_ctl <= eeprom.rom_value;
    end
    else if (wr_rom && rom_loaded)
    begin
      rom_ctl <= reg_wdata;
    end
  end

  // ==========================================================================
  // Address windows.
  logic        img_match;
  logic [15:0] img_hi;
  logic        rom_match;
  logic [15:0] rom_hi;

  ptid_window #(.CODE_W(4)) u_img1 (
    .addr_hi         (req.addr[31:16]),
    .base            (base_eff),
    .xlate           (xlate_addr_field),
    .block_size_code (block_size_code),
    .hit             (img_match),
    .out_hi          (img_hi)
  );

  ptid_window #(.CODE_W(3)) u_rom (
    .addr_hi         (req.addr[31:16]),
    .base            (cfg.rom_base),
    .xlate           (rom_ctl[`PTID_ROM_TA_HI:`PTID_ROM_TA_LO]),
    .block_size_code (rom_ctl[`PTID_ROM_BS_HI:`PTID_ROM_BS_LO]),
    .hit             (rom_match),
    .out_hi          (rom_hi)
  );

  // ==========================================================================
  // Claim and attribute generation, registered one cycle after the phase.
  logic       img_claim;
  logic       rom_claim;
  ptid_resp_t next_resp;

  assign img_claim = req.valid && !req.rom && img_en
                     && (req.io_space == pci_space_select)
                     && img_match;
  assign rom_claim = req.valid && req.rom && cfg.rom_enable && rom_match;

  always_comb
  begin
    next_resp                 = '0;
    next_resp.claim           = img_claim || rom_claim;
    next_resp.rom_hit         = rom_claim;
    next_resp.byte_order      = local_byte_order_setting;
    if (rom_claim)
    begin
      next_resp.local_addr      = {rom_hi, req.addr[15:0]};
      next_resp.local_txn_code  = rom_ctl[`PTID_ROM_TC_HI:`PTID_ROM_TC_LO];
      next_resp.dest_port_width = rom_ctl[`PTID_ROM_DS_HI:`PTID_ROM_DS_LO];
    end
    else if (img_claim)
    begin
      next_resp.local_addr      = {img_hi, req.addr[15:0]};
      next_resp.local_txn_code  = local_txn_code;
      next_resp.dest_port_width = dest_port_width;
      next_resp.byte_order      = local_byte_order_setting ^ byte_order_invert;
      next_resp.prefetch_ok     = prefetch_read_on && !req.write;
      next_resp.burst_ok        = burst_write_on && req.write && req.burst;
      next_resp.post_ok         = posted_write_on && req.write
                                  && (req.io_space == `PTID_SPACE_MEM);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resp <= '0;
    end
    else
    begin
      resp <= next_resp;
    end
  end

  // ==========================================================================
  // Register read port; unmapped offsets read zero.
  logic [31:0] ctl_view;
  logic [31:0] next_rdata;

  always_comb
  begin
    ctl_view                                 = `PTID_ZERO32;
    ctl_view[`PTID_CTL_EN]                   = img_en;
    ctl_view[`PTID_CTL_BS_HI:`PTID_CTL_BS_LO] = block_size_code;
    ctl_view[`PTID_CTL_PREFETCH_READ_ON]                 = prefetch_read_on;
    ctl_view[`PTID_CTL_BRST]                 = burst_write_on;
    ctl_view[`PTID_CTL_INV]                  = byte_order_invert;
    ctl_view[`PTID_CTL_TC_HI:`PTID_CTL_TC_LO] = local_txn_code;
    ctl_view[`PTID_CTL_DS_HI:`PTID_CTL_DS_LO] = dest_port_width;
    ctl_view[`PTID_CTL_POSTED_WRITE_ON]                 = posted_write_on;
    ctl_view[`PTID_CTL_PAS]                  = pci_space_select;
    case (reg_addr)
      `PTID_OFS_IMG1_CTL:  next_rdata = ctl_view;
      `PTID_OFS_IMG1_ADDR: next_rdata = {base_eff, xlate_addr_field};
      `PTID_OFS_ROM_CTL:   next_rdata = rom_ctl;
      default:             next_rdata = `PTID_ZERO32;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= `PTID_ZERO32;
      reg_ack   <= 1'b0;
    end
    else
    begin
      reg_ack   <= reg_rd || reg_wr;
      reg_rdata <= reg_rd ? next_rdata : `PTID_ZERO32;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_image1_base_reg_on <= 1'b0;
    end
    else
    begin
      cfg_image1_base_reg_on <= bst1_on;
    end
  end

endmodule

/* rtl/ptid_window.sv */
`timescale 1ns/1ns

// Compares the upper address lines selected by a block-size code against a
// base and substitutes the translation bits on the compared lines only.
module ptid_window
  import ptid_pkg::*;
#(
  parameter int CODE_W = 4
)
(
  input  wire logic [15:0]       addr_hi,
  input  wire logic [15:0]       base,
  input  wire logic [15:0]       xlate,
  input  wire logic [CODE_W-1:0] block_size_code,
  output logic                   hit,
  output logic      [15:0]       out_hi
);

  logic [15:0] cmp_mask;
  logic [15:0] bit_ok;

  // ==========================================================================
  // Line 16+i takes part when i is not below the size code.
  for (genvar i = 0; i < 16; i++)
  begin : g_line
    assign cmp_mask[i] = (5'(i) >= 5'(block_size_code));
    assign bit_ok[i]   = !cmp_mask[i] || (addr_hi[i] == base[i]);
    assign out_hi[i]   = cmp_mask[i] ? xlate[i] : addr_hi[i];
  end

  assign hit = &bit_ok;

endmodule

/* tb/ptid_pci_initiator.sv */
`timescale 1ns/1ns

// ==========================================================================
// Initiator model: one address phase per call; hold keeps valid for a
// back-to-back phase. Released lines carry the inverse so stale data shows.
module ptid_pci_initiator
  import ptid_pkg::*;
(
  input  wire logic clk,
  output ptid_req_t req
);
  initial req = '0;

  task automatic issue(input logic [31:0] a, input logic io, input logic rom,
                       input logic wr, input logic bst, input logic hold);
    @(posedge clk);
    req <= '{1'b1, a, io, rom, wr, bst};
    if (!hold)
    begin
      @(posedge clk);
      req <= '{1'b0, ~a, ~io, ~rom, ~wr, ~bst};
    end
  endtask
endmodule

/* tb/ptid_target_decode_monitor.sv */
`timescale 1ns/1ns

// ==========================================================================
// Port checks; outputs are registered, so each answer is tied to last cycle.
module ptid_target_decode_monitor
  import ptid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire ptid_cfg_t   cfg,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire ptid_req_t   req,
  input  wire ptid_resp_t  resp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack)
    else $error("register ack missing");
  chk_ack_spurious: assert property (!(reg_rd || reg_wr) |=> !reg_ack)
    else $error("register ack without strobe");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  chk_claim_cause: assert property (resp.claim |-> $past(req.valid))
    else $error("claim without address phase");
  chk_miss_quiet: assert property (!resp.claim |-> !resp.rom_hit && !resp.post_ok
      && resp.local_addr == 32'h0000_0000 && !resp.burst_ok && !resp.prefetch_ok)
    else $error("attributes without claim");
  chk_low_lines: assert property (resp.claim |->
      resp.local_addr[15:0] == $past(req.addr[15:0]))
    else $error("low address lines altered");
  chk_prefetch_read: assert property (resp.prefetch_ok |-> !$past(req.write))
    else $error("prefetch on a write");
  chk_burst_write: assert property (resp.burst_ok |->
      $past(req.write && req.burst))
    else $error("burst permission without burst write");
  chk_post_memory: assert property (resp.post_ok |->
      $past(req.write && !req.io_space))
    else $error("posting outside memory writes");
  chk_rom_source: assert property (resp.rom_hit |->
      $past(req.rom && cfg.rom_enable))
    else $error("rom hit without rom access");
endmodule

bind ptid_target_decode ptid_target_decode_monitor i_mon (
  .clk       (clk),
  .reset     (reset),
  .cfg       (cfg),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .reg_ack   (reg_ack),
  .req       (req),
  .resp      (resp)
);

/* tb/ptid_target_decode_tb_top.sv */
`timescale 1ns/1ns

module ptid_target_decode_tb_top
  import ptid_pkg::*;
;
  // ==========================================================================
  // Rows: flags are {io, write, burst, claim expected}.
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] areg;
    logic [31:0] addr;
    logic [3:0]  flags;
    logic [31:0] laddr;
  } ptid_row_t;

  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         pci_reset_pin = 1'b1;
  logic         dis_strap = 1'b0;
  logic         id_strap = 1'b0;
  logic         order = 1'b0;
  ptid_eeprom_t eeprom = '0;
  ptid_cfg_t    cfg = '0;
  logic [11:0]  reg_addr = 12'h000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_wdata = 32'h0000_0000;
  logic [31:0]  reg_rdata;
  logic [31:0]  q;
  logic         reg_ack;
  logic         base_on;
  logic [3:0]   f;
  ptid_req_t    req;
  ptid_resp_t   resp;
  ptid_eeprom_t e;
  ptid_row_t    rows [11];
  int           failures = 0;
  int           n_tests = 0;

  always #5 clk = ~clk;

  ptid_pci_initiator i_ini (.clk(clk), .req(req));

  ptid_target_decode i_dut (
    .clk                      (clk),
    .reset                    (reset),
    .pci_reset_pin            (pci_reset_pin),
    .pci_disable_strap        (dis_strap),
    .eeprom_ident_strap       (id_strap),
    .local_byte_order_setting (order),
    .eeprom                   (eeprom),
    .cfg                      (cfg),
    .reg_addr                 (reg_addr),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .reg_ack                  (reg_ack),
    .req                      (req),
    .resp                     (resp),
    .cfg_image1_base_reg_on   (base_on)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_cycle(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
    check("reg_ack", reg_ack, 1'b1);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    reg_cycle(1'b0, a, 32'h0000_0000);
    check(what, q, exp);
  endtask

  // Straps are sampled while the pin is held; load data follows release.
  task automatic pci_reset(input logic dis, input logic ident, input ptid_eeprom_t ee);
    @(posedge clk);
    pci_reset_pin <= 1'b1;
    dis_strap     <= dis;
    id_strap      <= ident;
    repeat (5) @(posedge clk);
    pci_reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    eeprom <= ee;
    @(posedge clk);
    eeprom <= '0;
    // The presence output is one flop behind the load status, so wait for it.
    repeat (2) @(posedge clk);
  endtask

  task automatic send(input logic [31:0] a, input logic io, input logic rom);
    i_ini.issue(a, io, rom, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
  endtask

  initial
  begin
    #100000;
    failures++;
    $display("[ERR] watchdog expected finish seen timeout");
    conclude();
  end

  initial
  begin
    rows[0]  = '{32'h8000_0000, 32'h1234_ABCD, 32'h1234_5678, 4'h1, 32'hABCD_5678};
    rows[1]  = '{32'h8000_0000, 32'h1234_ABCD, 32'h1235_5678, 4'h0, 32'h0000_0000};
    rows[2]  = '{32'h8F00_0000, 32'h8000_0000, 32'hFFFF_0001, 4'h1, 32'h7FFF_0001};
    rows[3]  = '{32'h8400_0000, 32'h5A30_C3F0, 32'h5A3B_0000, 4'h1, 32'hC3FB_0000};
    rows[4]  = '{32'h8100_0000, 32'h0002_0002, 32'h0003_0010, 4'h1, 32'h0003_0010};
    rows[5]  = '{32'h0000_0000, 32'h1234_1234, 32'h1234_0000, 4'h0, 32'h0000_0000};
    rows[6]  = '{32'h8000_0000, 32'h1234_1234, 32'h1234_0000, 4'h8, 32'h0000_0000};
    rows[7]  = '{32'h8000_0040, 32'h1234_1234, 32'h1234_0000, 4'h9, 32'h1234_0000};
    rows[8]  = '{32'h80D0_A880, 32'h1234_1234, 32'h1234_0000, 4'h7, 32'h1234_0000};
    rows[9]  = '{32'h80D0_A880, 32'h1234_1234, 32'h1234_0000, 4'h1, 32'h1234_0000};
    rows[10] = '{32'h8000_00C0, 32'h1234_1234, 32'h1234_0000, 4'hD, 32'h1234_0000};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    e = '0;
    e.done = 1'b1;
    pci_reset(1'b0, 1'b0, e);
    rd_chk("ctl reset", 12'h110, 32'h0000_0000);
    rd_chk("addr reset", 12'h114, 32'h0000_0000);
    rd_chk("rom reset", 12'h13c, 32'h0000_0000);
    check("base reg on", base_on, 1'b0);
    reg_cycle(1'b1, 12'h13c, 32'hFFFF_FFFF);
    rd_chk("rom locked", 12'h13c, 32'h0000_0000);
    reg_cycle(1'b1, 12'h110, 32'hFFFF_FFFF);
    rd_chk("ctl mask", 12'h110, 32'h8FD0_FCC0);
    rd_chk("unmapped", 12'h120, 32'h0000_0000);
    $display("test reset_values done");
    foreach (rows[i])
    begin
      order <= i[0];
      reg_cycle(1'b1, 12'h110, rows[i].ctl);
      reg_cycle(1'b1, 12'h114, rows[i].areg);
      rd_chk("addr rw", 12'h114, rows[i].areg);
      f = rows[i].flags;
      i_ini.issue(rows[i].addr, f[3], 1'b0, f[2], f[1], 1'b0);
      @(posedge clk);
      check("claim", resp.claim, f[0]);
      check("local_addr", resp.local_addr, rows[i].laddr);
      if (f[0])
      begin
        check("txn_code", resp.local_txn_code, rows[i].ctl[15:12]);
        check("port_width", resp.dest_port_width, rows[i].ctl[11:10]);
        check("byte_order", resp.byte_order, rows[i].ctl[20] ^ i[0]);
        check("prefetch", resp.prefetch_ok, rows[i].ctl[23] & ~f[2]);
        check("burst", resp.burst_ok, rows[i].ctl[22] & f[2] & f[1]);
        check("post", resp.post_ok, rows[i].ctl[7] & f[2] & ~f[3]);
      end
    end
    $display("test decode_table done");
    reg_cycle(1'b1, 12'h110, 32'h8000_0000);
    reg_cycle(1'b1, 12'h114, 32'h1234_ABCD);
    i_ini.issue(32'h1234_0004, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    i_ini.issue(32'h5678_0008, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("first of pair", resp.local_addr, 32'hABCD_0004);
    @(posedge clk);
    check("second of pair", resp.claim, 1'b0);
    $display("test back_to_back done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk("ctl greset", 12'h110, 32'h0000_0000);
    rd_chk("addr greset", 12'h114, 32'h0000_0000);
    $display("test global_reset done");
    cfg <= '{16'h7700, 1'b1, 16'h0040, 1'b1};
    e = '{1'b1, 1'b1, 4'h3, 1'b1, 1'b1, 1'b1, 32'h0125_BEEF};
    pci_reset(1'b0, 1'b1, e);
    check("base reg on", base_on, 1'b1);
    rd_chk("rom loaded", 12'h13c, 32'h0125_BEEF);
    reg_cycle(1'b1, 12'h110, 32'h8000_0000);
    rd_chk("ctl loaded", 12'h110, 32'h8300_0040);
    reg_cycle(1'b1, 12'h114, 32'h1111_2222);
    rd_chk("addr mirror", 12'h114, 32'h7700_2222);
    send(32'h7707_0000, 1'b1, 1'b0);
    check("loaded claim", resp.claim, 1'b1);
    check("loaded addr", resp.local_addr, 32'h2227_0000);
    send(32'h0041_2345, 1'b0, 1'b1);
    check("rom hit", resp.rom_hit, 1'b1);
    check("rom addr", resp.local_addr, 32'hBEED_2345);
    check("rom code", resp.local_txn_code, 4'h5);
    check("rom width", resp.dest_port_width, 2'h1);
    send(32'h0081_0000, 1'b0, 1'b1);
    check("rom miss", resp.rom_hit, 1'b0);
    $display("test eeprom_preload done");
    pci_reset(1'b1, 1'b1, e);
    reg_cycle(1'b1, 12'h110, 32'h8500_0000);
    rd_chk("ctl strap", 12'h110, 32'h8500_0000);
    rd_chk("addr strap", 12'h114, 32'h7700_2222);
    $display("test disable_strap done");
    conclude();
  end
endmodule
